// ===== rtl/hub_cmd_core.sv
`timescale 1ns/100ps
// Contract
// - codes 40h-4Dh plus one byte: bit0 stalls or unstalls that endpoint
// - a SETUP token unstalls both control endpoints unconditionally
// - unstalling flushes the buffer and returns its toggle to DATA0; a SETUP unstall flushes only the IN buffer (endpoint 1)
// - writing zero to an unstalled endpoint still reinitialises it
// - SETUP flushes IN buffer and blocks buffer validate and clear
// - E0h-E1h clear, E8h-E9h set a port feature, one byte follows
// - feature codes 0..7 decode; codes 4..7 only clear
// - mode 0: power and overcurrent change are hub wide
// - mode 1: per-port overcurrent inputs and change bits; clearing overcurrent change clears both ports
// - set power: on first, arm overcurrent second; clear turns both off
// - status query returns status byte then change byte
// - reset status bit stays high for the 10 ms port reset
// - status reports connect, enable, suspend, overcurrent, power, low speed
// - change bits set on change and hold until cleared
// - F7h byte: bit0 local power change, bit1 embedded change into hub
// - F6h drives upstream resume for 10 ms
// - downstream events start upstream resume by themselves
// - F5h reads last good frame number, low byte first
// - babble disables the embedded function automatically
module hub_cmd_core #(
   parameter int PORT_RESET_CYC = hub_cmd_pkg::PORT_RESET_CYC,
   parameter int RESUME_CYC = hub_cmd_pkg::RESUME_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic mode_i,
   input wire logic link_clk_i,
   input wire logic setup_i,
   input wire logic sof_i,
   input wire logic babble_i,
   input wire logic [10:0] frame_i,
   input wire logic [1:0] connect_i,
   input wire logic [1:0] low_speed_i,
   input wire logic [1:0] overcur_i,
   output logic [13:0] stall_o,
   output logic [13:0] flush_o,
   output logic [13:0] toggle_o,
   output logic buf_blocked_o,
   output logic buf_clear_o,
   output logic buf_valid_o,
   output logic power_o,
   output logic [1:0] port_en_o,
   output logic [1:0] port_susp_o,
   output logic [1:0] port_rst_o,
   output logic resume_o,
   output logic emb_off_o,
   output logic [3:0] hub_chg_o
);
   localparam logic [hub_cmd_pkg::CNT_W-1:0] RST_LOAD = hub_cmd_pkg::CNT_W'(PORT_RESET_CYC - 1);
   localparam logic [hub_cmd_pkg::CNT_W-1:0] RES_LOAD = hub_cmd_pkg::CNT_W'(RESUME_CYC - 1);

   typedef struct packed {
      logic [hub_cmd_pkg::SY_W-1:0] sy1;
      logic [hub_cmd_pkg::SY_W-1:0] sy2;
      logic link_prev;
      logic mode;
      logic [1:0] mode_age;
      hub_cmd_pkg::cmd_phase_t phase;
      logic [7:0] cmd;
      logic byte_cnt;
      logic [3:0] sel_ep;
      logic [7:0] rdata;
      logic [13:0] stall;
      logic [13:0] flush;
      logic [13:0] toggle;
      logic [1:0] lock;
      logic blocked;
      logic buf_clear;
      logic buf_valid;
      logic power;
      logic oc_arm;
      logic [1:0] en;
      logic [1:0] susp;
      logic [1:0] rst;
      logic [1:0][hub_cmd_pkg::CNT_W-1:0] rst_cnt;
      logic [1:0] conn_prev;
      logic [1:0] oc_prev;
      logic [1:0] chg_conn;
      logic [1:0] chg_en;
      logic [1:0] chg_susp;
      logic [1:0] chg_rst;
      logic [1:0] chg_oc;
      logic [1:0] ext_chg;
      logic resume;
      logic [hub_cmd_pkg::CNT_W-1:0] res_cnt;
      logic [10:0] frame;
      logic emb_off;
      logic [3:0] hub_chg;
   } state_t;

   state_t r_ff;
   state_t nxt_r;

   // overcurrent seen by port p: one shared input in mode 0
   function automatic logic oc_of(input logic mode, input logic [1:0] oc, input int p);
      oc_of = mode ? oc[p] : oc[0];
   endfunction

   // status byte of one port
   function automatic logic [7:0] status_of(input state_t s, input int p);
      logic [7:0] b;
      b = 8'h00;
      b[hub_cmd_pkg::ST_CONNECT] = s.conn_prev[p];
      b[hub_cmd_pkg::ST_ENABLE] = s.en[p];
      b[hub_cmd_pkg::ST_SUSPEND] = s.susp[p];
      b[hub_cmd_pkg::ST_OVERCUR] = s.oc_prev[p];
      b[hub_cmd_pkg::ST_RESET] = s.rst[p];
      b[hub_cmd_pkg::ST_POWER] = s.power;
      b[hub_cmd_pkg::ST_LOWSPEED] = s.conn_prev[p] & s.sy2[hub_cmd_pkg::SY_LS + p];
      status_of = b;
   endfunction

   // change byte of one port
   function automatic logic [7:0] change_of(input state_t s, input int p);
      logic [7:0] b;
      b = 8'h00;
      b[hub_cmd_pkg::ST_CONNECT] = s.chg_conn[p];
      b[hub_cmd_pkg::ST_ENABLE] = s.chg_en[p];
      b[hub_cmd_pkg::ST_SUSPEND] = s.chg_susp[p];
      b[hub_cmd_pkg::ST_OVERCUR] = s.chg_oc[p];
      b[hub_cmd_pkg::ST_RESET] = s.chg_rst[p];
      change_of = b;
   endfunction

   logic link_edge;
   logic setup_ev;
   logic sof_ev;
   logic babble_ev;
   logic data_wr;
   logic first_wr;
   logic [3:0] ep_idx;
   logic port_idx;
   logic [1:0] oc_now;

   // link strobes are sampled only on a detected link clock rising edge
   assign link_edge = r_ff.sy2[hub_cmd_pkg::SY_LINK] & ~r_ff.link_prev;
   assign setup_ev = link_edge & r_ff.sy2[hub_cmd_pkg::SY_SETUP];
   assign sof_ev = link_edge & r_ff.sy2[hub_cmd_pkg::SY_SOF];
   assign babble_ev = link_edge & r_ff.sy2[hub_cmd_pkg::SY_BABBLE];
   assign data_wr = wr_i && addr_i == hub_cmd_pkg::ADDR_DATA;
   assign first_wr = data_wr && r_ff.phase == hub_cmd_pkg::PH_DATA;
   assign ep_idx = r_ff.cmd[3:0];
   assign port_idx = r_ff.cmd[0];
   assign oc_now[0] = r_ff.oc_arm & oc_of(r_ff.mode, r_ff.sy2[hub_cmd_pkg::SY_OC +: 2], 0);
   assign oc_now[1] = r_ff.oc_arm & oc_of(r_ff.mode, r_ff.sy2[hub_cmd_pkg::SY_OC +: 2], 1);

   // next state: software clears first, hardware sets last so sets win
   always_comb begin
      logic [7:0] f;
      logic is_set;
      f = wdata_i;
      is_set = r_ff.cmd == hub_cmd_pkg::CMD_FEAT_SET0 || r_ff.cmd == hub_cmd_pkg::CMD_FEAT_SET1;
      nxt_r = r_ff;
      nxt_r.sy1 = {overcur_i, low_speed_i, connect_i, frame_i, mode_i, babble_i, sof_i,
                   setup_i, link_clk_i};
      nxt_r.sy2 = r_ff.sy1;
      nxt_r.link_prev = r_ff.sy2[hub_cmd_pkg::SY_LINK];
      nxt_r.flush = 14'h0000;
      nxt_r.buf_clear = 1'b0;
      nxt_r.buf_valid = 1'b0;
      nxt_r.rdata = 8'h00;
      // strap taken once the sync stages hold pin values, not their reset zeros
      if (r_ff.mode_age != 2'h3) begin
         nxt_r.mode_age = r_ff.mode_age + 2'h1;
      end
      if (r_ff.mode_age == hub_cmd_pkg::MODE_AGE_TAKE) begin
         nxt_r.mode = r_ff.sy2[hub_cmd_pkg::SY_MODE];
      end
      // upstream resume timer first, so a new command or event restarts it
      if (r_ff.resume) begin
         if (r_ff.res_cnt == '0) begin
            nxt_r.resume = 1'b0;
         end else begin
            nxt_r.res_cnt = r_ff.res_cnt - 1'b1;
         end
      end
      // command byte
      if (wr_i && addr_i == hub_cmd_pkg::ADDR_CMD) begin
         nxt_r.cmd = wdata_i;
         nxt_r.byte_cnt = 1'b0;
         nxt_r.phase = hub_cmd_pkg::PH_DATA;
         if (wdata_i <= hub_cmd_pkg::CMD_SEL_LAST) begin
            nxt_r.sel_ep = wdata_i[3:0];
         end else if (wdata_i == hub_cmd_pkg::CMD_SETUP_ACK) begin
            nxt_r.lock[r_ff.sel_ep[0]] = 1'b0;
         end else if (wdata_i == hub_cmd_pkg::CMD_BUF_CLEAR) begin
            nxt_r.buf_clear = r_ff.lock == 2'b00;
         end else if (wdata_i == hub_cmd_pkg::CMD_BUF_VALID) begin
            nxt_r.buf_valid = r_ff.lock == 2'b00;
         end else if (wdata_i == hub_cmd_pkg::CMD_RESUME) begin
            nxt_r.resume = 1'b1;
            nxt_r.res_cnt = RES_LOAD;
         end
      end
      // single data byte commands; later bytes land in PH_DONE and are dropped
      if (first_wr) begin
         nxt_r.phase = hub_cmd_pkg::PH_DONE;
         if (r_ff.cmd >= hub_cmd_pkg::CMD_STALL_FIRST &&
             r_ff.cmd <= hub_cmd_pkg::CMD_STALL_LAST) begin
            nxt_r.stall[ep_idx] = wdata_i[0];
            if (!wdata_i[0]) begin
               nxt_r.flush[ep_idx] = 1'b1;
               nxt_r.toggle[ep_idx] = 1'b0;
            end
         end else if (r_ff.cmd == hub_cmd_pkg::CMD_HUB_CHG) begin
            nxt_r.ext_chg = wdata_i[1:0];
         end else if (is_set || r_ff.cmd == hub_cmd_pkg::CMD_FEAT_CLR0 ||
                      r_ff.cmd == hub_cmd_pkg::CMD_FEAT_CLR1) begin
            if (f == hub_cmd_pkg::FEAT_ENABLE) begin
               nxt_r.en[port_idx] = is_set;
            end else if (f == hub_cmd_pkg::FEAT_SUSPEND) begin
               nxt_r.susp[port_idx] = is_set;
            end else if (f == hub_cmd_pkg::FEAT_PORT_RESTART) begin
               if (is_set) begin
                  nxt_r.rst[port_idx] = 1'b1;
                  nxt_r.rst_cnt[port_idx] = RST_LOAD;
               end else begin
                  nxt_r.chg_rst[port_idx] = 1'b0;
               end
            end else if (f == hub_cmd_pkg::FEAT_POWER) begin
               // gang switch, so the port number never matters here
               if (!is_set) begin
                  nxt_r.power = 1'b0;
                  nxt_r.oc_arm = 1'b0;
               end else if (!r_ff.power) begin
                  nxt_r.power = 1'b1;
               end else begin
                  nxt_r.oc_arm = 1'b1;
               end
            end else if (!is_set && f == hub_cmd_pkg::FEAT_C_CONN) begin
               nxt_r.chg_conn[port_idx] = 1'b0;
            end else if (!is_set && f == hub_cmd_pkg::FEAT_C_ENABLE) begin
               nxt_r.chg_en[port_idx] = 1'b0;
            end else if (!is_set && f == hub_cmd_pkg::FEAT_C_SUSPEND) begin
               nxt_r.chg_susp[port_idx] = 1'b0;
            end else if (!is_set && f == hub_cmd_pkg::FEAT_C_OVERCUR) begin
               nxt_r.chg_oc = 2'b00;
            end
            if (!is_set && f == hub_cmd_pkg::FEAT_SUSPEND && r_ff.susp[port_idx]) begin
               nxt_r.chg_susp[port_idx] = 1'b1;
            end
         end
      end
      // reads: status then change byte, or frame low then high; a third read gives zero
      if (rd_i && addr_i == hub_cmd_pkg::ADDR_DATA && r_ff.phase == hub_cmd_pkg::PH_DATA) begin
         nxt_r.byte_cnt = 1'b1;
         if (r_ff.cmd == hub_cmd_pkg::CMD_FEAT_CLR0 || r_ff.cmd == hub_cmd_pkg::CMD_FEAT_CLR1) begin
            nxt_r.rdata = r_ff.byte_cnt ? change_of(r_ff, int'(port_idx)) :
                          status_of(r_ff, int'(port_idx));
         end else if (r_ff.cmd == hub_cmd_pkg::CMD_FRAME) begin
            nxt_r.rdata = r_ff.byte_cnt ? {5'h00, r_ff.frame[10:8]} :
                          r_ff.frame[7:0];
         end
         if (r_ff.byte_cnt) begin
            nxt_r.phase = hub_cmd_pkg::PH_DONE;
         end
      end
      // port reset timers
      for (int p = 0; p < hub_cmd_pkg::NUM_PORT; p++) begin
         if (r_ff.rst[p]) begin
            if (r_ff.rst_cnt[p] == '0) begin
               nxt_r.rst[p] = 1'b0;
               nxt_r.chg_rst[p] = 1'b1;
               nxt_r.en[p] = 1'b1;
            end else begin
               nxt_r.rst_cnt[p] = r_ff.rst_cnt[p] - 1'b1;
            end
         end
      end
      // downstream connect and overcurrent changes
      for (int p = 0; p < hub_cmd_pkg::NUM_PORT; p++) begin
         nxt_r.conn_prev[p] = r_ff.sy2[hub_cmd_pkg::SY_CONN + p];
         nxt_r.oc_prev[p] = oc_now[p];
         if (r_ff.conn_prev[p] != r_ff.sy2[hub_cmd_pkg::SY_CONN + p]) begin
            nxt_r.chg_conn[p] = 1'b1;
            nxt_r.resume = 1'b1;
            nxt_r.res_cnt = RES_LOAD;
            if (!r_ff.sy2[hub_cmd_pkg::SY_CONN + p]) begin
               if (r_ff.en[p]) begin
                  nxt_r.chg_en[p] = 1'b1;
               end
               nxt_r.en[p] = 1'b0;
            end
         end
         if (r_ff.oc_prev[p] != oc_now[p]) begin
            nxt_r.chg_oc[p] = 1'b1;
            nxt_r.resume = 1'b1;
            nxt_r.res_cnt = RES_LOAD;
         end
      end
      // setup arrival on the control pair: unstall, reinit, lock buffer commands
      if (setup_ev) begin
         nxt_r.stall[1:0] = 2'b00;
         nxt_r.toggle[1:0] = 2'b00;
         nxt_r.flush[1] = 1'b1;
         nxt_r.lock = 2'b11;
      end
      if (sof_ev) begin
         nxt_r.frame = r_ff.sy2[hub_cmd_pkg::SY_FRAME +: hub_cmd_pkg::FRAME_W];
      end
      if (babble_ev) begin
         nxt_r.emb_off = 1'b1;
      end else if (first_wr && r_ff.cmd == hub_cmd_pkg::CMD_HUB_CHG) begin
         nxt_r.emb_off = 1'b0;
      end
      nxt_r.hub_chg = {|{change_of(r_ff, 1)}, |{change_of(r_ff, 0)}, r_ff.ext_chg};
      nxt_r.blocked = |nxt_r.lock;
   end

   // one register for the whole state
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_ff <= '0;
         r_ff.phase <= hub_cmd_pkg::PH_IDLE;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign rdata_o = r_ff.rdata;
   assign stall_o = r_ff.stall;
   assign flush_o = r_ff.flush;
   assign toggle_o = r_ff.toggle;
   assign buf_blocked_o = r_ff.blocked;
   assign buf_clear_o = r_ff.buf_clear;
   assign buf_valid_o = r_ff.buf_valid;
   assign power_o = r_ff.power;
   assign port_en_o = r_ff.en;
   assign port_susp_o = r_ff.susp;
   assign port_rst_o = r_ff.rst;
   assign resume_o = r_ff.resume;
   assign emb_off_o = r_ff.emb_off;
   assign hub_chg_o = r_ff.hub_chg;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_stall_write_bit: assert property (
      first_wr && r_ff.cmd == hub_cmd_pkg::CMD_STALL_FIRST
      |=> stall_o[0] == $past(wdata_i[0])) else $error("stall bit not taken");
   a_setup_unstalls: assert property (
      setup_ev |=> stall_o[1:0] == 2'b00 && buf_blocked_o)
      else $error("setup did not unstall");
   a_unstall_reinit: assert property (
      first_wr && r_ff.cmd == hub_cmd_pkg::CMD_STALL_FIRST
      && !wdata_i[0] |=> flush_o[0] && !toggle_o[0] ##1 !flush_o[0])
      else $error("no reinit on unstall");
   a_zero_reinit: assert property (
      first_wr && r_ff.cmd >= hub_cmd_pkg::CMD_STALL_FIRST
      && r_ff.cmd <= hub_cmd_pkg::CMD_STALL_LAST
      && !stall_o[ep_idx] && wdata_i == 8'h00 |=> flush_o[$past(ep_idx)])
      else $error("zero write did not reinit");
   a_buf_blocked: assert property (
      wr_i && addr_i == hub_cmd_pkg::ADDR_CMD
      && wdata_i == hub_cmd_pkg::CMD_BUF_CLEAR && buf_blocked_o |=> !buf_clear_o)
      else $error("buffer clear passed while blocked");
   a_power_twice: assert property (
      first_wr && (r_ff.cmd == hub_cmd_pkg::CMD_FEAT_SET0 ||
      r_ff.cmd == hub_cmd_pkg::CMD_FEAT_SET1)
      && wdata_i == hub_cmd_pkg::FEAT_POWER && !power_o |=> power_o && !r_ff.oc_arm)
      else $error("power set armed overcurrent early");
   a_reset_holds: assert property (
      $rose(port_rst_o[0]) |-> port_rst_o[0] [*8])
      else $error("port reset ended early");
   a_status_power: assert property (
      rd_i && addr_i == hub_cmd_pkg::ADDR_DATA
      && r_ff.cmd == hub_cmd_pkg::CMD_FEAT_CLR0 && !r_ff.byte_cnt
      && r_ff.phase == hub_cmd_pkg::PH_DATA
      |=> rdata_o[hub_cmd_pkg::ST_POWER] == $past(power_o))
      else $error("status byte power wrong");
   a_resume_cmd: assert property (
      wr_i && addr_i == hub_cmd_pkg::ADDR_CMD
      && wdata_i == hub_cmd_pkg::CMD_RESUME |=> resume_o [*8])
      else $error("resume not driven");
   a_auto_resume: assert property (
      r_ff.conn_prev != r_ff.sy2[hub_cmd_pkg::SY_CONN +: 2]
      |=> resume_o) else $error("no resume on connect change");
   a_extra_ignored: assert property (
      wr_i && addr_i == hub_cmd_pkg::ADDR_DATA
      && r_ff.phase == hub_cmd_pkg::PH_DONE && !setup_ev |=> $stable(stall_o))
      else $error("extra byte changed stall");

   c_setup_then_ack: cover property (setup_ev ##[1:50] !buf_blocked_o);
   c_port_reset_done: cover property ($fell(port_rst_o[0]));
   c_frame_read: cover property (sof_ev ##[1:20] rd_i && r_ff.cmd == hub_cmd_pkg::CMD_FRAME);
endmodule

// ===== rtl/hub_cmd_pkg.sv
package hub_cmd_pkg;
   // core clock and documented times
   localparam int CLK_MHZ = 125;
   localparam int T_PORT_RESET_US = 10000;
   localparam int T_RESUME_US = 10000;
   localparam int PORT_RESET_CYC = T_PORT_RESET_US * CLK_MHZ;
   localparam int RESUME_CYC = T_RESUME_US * CLK_MHZ;
   localparam int CNT_W = 21;
   localparam int NUM_EP = 14;
   localparam int NUM_PORT = 2;
   localparam int FRAME_W = 11;
   // strap sampled once both sync stages hold pin values
   localparam logic [1:0] MODE_AGE_TAKE = 2'h2;

   // register port addresses
   localparam logic [1:0] ADDR_CMD = 2'h0;
   localparam logic [1:0] ADDR_DATA = 2'h1;

   // command codes
   localparam logic [7:0] CMD_SEL_LAST = 8'h0D;
   localparam logic [7:0] CMD_STALL_FIRST = 8'h40;
   localparam logic [7:0] CMD_STALL_LAST = 8'h4D;
   localparam logic [7:0] CMD_FEAT_CLR0 = 8'hE0;
   localparam logic [7:0] CMD_FEAT_CLR1 = 8'hE1;
   localparam logic [7:0] CMD_FEAT_SET0 = 8'hE8;
   localparam logic [7:0] CMD_FEAT_SET1 = 8'hE9;
   localparam logic [7:0] CMD_BUF_CLEAR = 8'hF2;
   localparam logic [7:0] CMD_SETUP_ACK = 8'hF1;
   localparam logic [7:0] CMD_FRAME = 8'hF5;
   localparam logic [7:0] CMD_RESUME = 8'hF6;
   localparam logic [7:0] CMD_HUB_CHG = 8'hF7;
   localparam logic [7:0] CMD_BUF_VALID = 8'hFA;

   // feature codes
   localparam logic [7:0] FEAT_ENABLE = 8'h00;
   localparam logic [7:0] FEAT_SUSPEND = 8'h01;
   localparam logic [7:0] FEAT_PORT_RESTART = 8'h02;
   localparam logic [7:0] FEAT_POWER = 8'h03;
   localparam logic [7:0] FEAT_C_CONN = 8'h04;
   localparam logic [7:0] FEAT_C_ENABLE = 8'h05;
   localparam logic [7:0] FEAT_C_SUSPEND = 8'h06;
   localparam logic [7:0] FEAT_C_OVERCUR = 8'h07;

   // port status and change byte bit positions
   localparam int ST_CONNECT = 0;
   localparam int ST_ENABLE = 1;
   localparam int ST_SUSPEND = 2;
   localparam int ST_OVERCUR = 3;
   localparam int ST_RESET = 4;
   localparam int ST_POWER = 5;
   localparam int ST_LOWSPEED = 6;

   // synchroniser bundle layout
   localparam int SY_LINK = 0;
   localparam int SY_SETUP = 1;
   localparam int SY_SOF = 2;
   localparam int SY_BABBLE = 3;
   localparam int SY_MODE = 4;
   localparam int SY_FRAME = 5;
   localparam int SY_CONN = 16;
   localparam int SY_LS = 18;
   localparam int SY_OC = 20;
   localparam int SY_W = 22;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b001,
      PH_DATA = 3'b010,
      PH_DONE = 3'b100
   } cmd_phase_t;
endpackage

// ===== verification/link_model.sv
`timescale 1ns/100ps
// far side of the link: event levels qualified by a link clock that only runs in frames
module link_model (
   output logic link_clk_o,
   output logic setup_o,
   output logic sof_o,
   output logic babble_o,
   output logic [10:0] frame_o
);
   initial begin
      link_clk_o = 1'b0;
      setup_o = 1'b0;
      sof_o = 1'b0;
      babble_o = 1'b0;
      frame_o = 11'h2aa;
   end

   // two 80 ns link cycles per event, then the clock stands still
   task automatic send(input logic s, input logic f, input logic b, input logic [10:0] fr);
      setup_o = s;
      sof_o = f;
      babble_o = b;
      frame_o = fr;
      repeat (2) begin
         #40 link_clk_o = 1'b1;
         #40 link_clk_o = 1'b0;
      end
      setup_o = 1'b0;
      sof_o = 1'b0;
      babble_o = 1'b0;
      // stale frame number must not look valid
      frame_o = ~fr;
   endtask
endmodule

// ===== verification/usb_hub_port_command_handler_tb.sv
`timescale 1ns/100ps
module usb_hub_port_command_handler_tb;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [1:0] conn = 2'h0;
   logic [1:0] ls = 2'h0;
   logic [1:0] oc = 2'h0;
   logic mode = 1'b0;
   logic [7:0] rdata, v;
   logic link_clk, setup, sof, babble, blocked, bclr, bval, power, resume, emb_off;
   logic [10:0] frame;
   logic [13:0] stall, flush, toggle;
   logic [1:0] port_en, port_susp, port_rst;
   logic [3:0] hub_chg;
   logic [13:0] flush_seen = 14'h0;
   logic [1:0] buf_seen = 2'h0;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;

   link_model link (.link_clk_o(link_clk), .setup_o(setup), .sof_o(sof),
      .babble_o(babble), .frame_o(frame));

   // short reset and resume counts keep the run brief
   hub_cmd_core #(.PORT_RESET_CYC(20), .RESUME_CYC(20)) uut (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .mode_i(mode), .link_clk_i(link_clk),
      .setup_i(setup), .sof_i(sof), .babble_i(babble), .frame_i(frame),
      .connect_i(conn), .low_speed_i(ls), .overcur_i(oc), .stall_o(stall),
      .flush_o(flush), .toggle_o(toggle), .buf_blocked_o(blocked), .buf_clear_o(bclr),
      .buf_valid_o(bval), .power_o(power), .port_en_o(port_en), .port_susp_o(port_susp),
      .port_rst_o(port_rst), .resume_o(resume), .emb_off_o(emb_off), .hub_chg_o(hub_chg));

   always #4 core_clk_i = ~core_clk_i;

   // one-cycle pulses are latched so late checks cannot miss them
   always @(posedge core_clk_i) begin
      flush_seen <= flush_seen | flush;
      buf_seen <= buf_seen | {bval, bclr};
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
      #1;
   endtask

   task automatic rd_reg(output logic [7:0] q);
      @(posedge core_clk_i);
      addr <= 2'h1;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1 q = rdata;
   endtask

   task automatic cmdd(input logic [7:0] c, input logic [7:0] d);
      wr_reg(2'h0, c);
      wr_reg(2'h1, d);
   endtask

   task automatic status(input logic [7:0] c, input logic [7:0] st, input logic [7:0] ch);
      wr_reg(2'h0, c);
      rd_reg(v);
      check(v, st);
      rd_reg(v);
      check(v, ch);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   initial begin
      idle(16);
      rst_n_i <= 1'b1;
      // stall, unstall with reinit, zero to an unstalled endpoint
      cmdd(8'h40, 8'h01);
      check(stall[0], 1'b1);
      cmdd(8'h41, 8'h01);
      cmdd(8'h40, 8'h00);
      check({flush[0], stall[0], toggle[0]}, 3'b100);
      cmdd(8'h4d, 8'h00);
      check(flush[13], 1'b1);
      // setup token unstalls both control endpoints and blocks buffer commands
      cmdd(8'h40, 8'h01);
      link.send(1'b1, 1'b0, 1'b0, 11'h000);
      idle(8);
      check({blocked, stall[1:0], toggle[1:0]}, 5'h10);
      check(flush_seen[1], 1'b1);
      wr_reg(2'h0, 8'hf2);
      wr_reg(2'h0, 8'hfa);
      idle(2);
      check(buf_seen, 2'b00);
      wr_reg(2'h0, 8'h00);
      wr_reg(2'h0, 8'hf1);
      wr_reg(2'h0, 8'h01);
      wr_reg(2'h0, 8'hf1);
      check(blocked, 1'b0);
      wr_reg(2'h0, 8'hfa);
      idle(2);
      check(buf_seen, 2'b10);
      // gang power: first set powers, second arms overcurrent
      cmdd(8'he9, 8'h03);
      check(power, 1'b1);
      oc <= 2'b01;
      idle(6);
      status(8'he0, 8'h20, 8'h00);
      cmdd(8'he8, 8'h03);
      idle(4);
      status(8'he1, 8'h28, 8'h08);
      cmdd(8'he0, 8'h07);
      status(8'he1, 8'h28, 8'h00);
      cmdd(8'he1, 8'h03);
      check(power, 1'b0);
      oc <= 2'b00;
      // disarming drops the overcurrent status, which raises its change bits again
      cmdd(8'he0, 8'h07);
      cmdd(8'he8, 8'h04);
      check({port_en, port_susp, port_rst}, 6'h00);
      // port restart runs its timed reset then enables
      cmdd(8'he8, 8'h02);
      check(port_rst[0], 1'b1);
      status(8'he0, 8'h10, 8'h00);
      idle(20);
      check({port_rst[0], port_en[0]}, 2'b01);
      status(8'he0, 8'h02, 8'h10);
      rd_reg(v);
      check(v, 8'h00);
      cmdd(8'he0, 8'h02);
      status(8'he0, 8'h02, 8'h00);
      // suspend and resume, then enable off and on
      cmdd(8'he8, 8'h01);
      check(port_susp[0], 1'b1);
      cmdd(8'he0, 8'h01);
      idle(2);
      check({port_susp[0], hub_chg[2]}, 2'b01);
      cmdd(8'he0, 8'h00);
      check(port_en[0], 1'b0);
      cmdd(8'he8, 8'h00);
      check(port_en[0], 1'b1);
      // unknown code and surplus data bytes do nothing
      cmdd(8'hc3, 8'hff);
      cmdd(8'h40, 8'h01);
      wr_reg(2'h1, 8'h00);
      check(stall[0], 1'b1);
      // commanded resume, then resume from a downstream connect
      idle(25);
      wr_reg(2'h0, 8'hf6);
      idle(10);
      check(resume, 1'b1);
      idle(15);
      check(resume, 1'b0);
      conn <= 2'b10;
      ls <= 2'b10;
      idle(8);
      check(resume, 1'b1);
      status(8'he1, 8'h41, 8'h01);
      // frame number, low byte first
      link.send(1'b0, 1'b1, 1'b0, 11'h5a3);
      idle(8);
      wr_reg(2'h0, 8'hf5);
      rd_reg(v);
      check(v, 8'ha3);
      rd_reg(v);
      check(v, 8'h05);
      // hub change merge and babble shutdown
      // controller reports the embedded port flags it keeps for reset and resume
      cmdd(8'hf7, 8'h03);
      idle(2);
      check(hub_chg[1:0], 2'b11);
      cmdd(8'hf7, 8'h00);
      idle(2);
      check(hub_chg[1:0], 2'b00);
      link.send(1'b0, 1'b0, 1'b1, 11'h000);
      idle(8);
      check(emb_off, 1'b1);
      // controller flags the babble as an embedded enable change
      cmdd(8'hf7, 8'h02);
      idle(2);
      check({emb_off, hub_chg[1]}, 2'b01);
      // mid-run reset with per-port overcurrent inputs strapped
      conn <= 2'b00;
      mode <= 1'b1;
      rst_n_i <= 1'b0;
      idle(2);
      rst_n_i <= 1'b1;
      cmdd(8'he8, 8'h03);
      cmdd(8'he9, 8'h03);
      oc <= 2'b10;
      idle(6);
      status(8'he0, 8'h20, 8'h00);
      status(8'he1, 8'h28, 8'h08);
      finish_test();
   end
endmodule
